// ---- rtl/sil_pkg.sv ----
package sil_pkg;
   // register offsets
   localparam logic [7:0] ADDR_MODE_SELECT = 8'h04;
   localparam logic [7:0] ADDR_I2C_CONTROL = 8'h05;
   localparam logic [7:0] ADDR_REMOTE_DESER_ID = 8'h06;
   localparam logic [7:0] ADDR_REMOTE_SLAVE0_TARGET = 8'h07;
   localparam logic [7:0] ADDR_REMOTE_SLAVE0_ALIAS = 8'h08;
   localparam logic [7:0] ADDR_CRC_ERROR_COUNT_LOW = 8'h0A;
   localparam logic [7:0] ADDR_CRC_ERROR_COUNT_HIGH = 8'h0B;
   localparam logic [7:0] ADDR_GENERAL_STATUS = 8'h0C;

   // field positions
   localparam int MODE_COUNTER_CLEAR_BIT = 5;
   localparam int I2C_WD_SPEEDUP_BIT = 1;
   localparam int I2C_WD_DISABLE_BIT = 0;
   localparam logic [7:0] I2C_CONTROL_MASK = 8'h1F;
   localparam int ID_HOLD_BIT = 0;
   localparam int STATUS_SELFTEST_CRC_BIT = 3;
   localparam int STATUS_PCLK_DETECT_BIT = 2;
   localparam int STATUS_DESER_ERROR_BIT = 1;
   localparam int STATUS_LINK_DETECT_BIT = 0;

   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [6:0] RESET_ADDR7 = 7'h00;
   localparam logic [15:0] RESET_COUNT = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   // timing
   localparam int CLK_MHZ = 50;
   localparam int WD_LONG_US = 1000000;
   localparam int WD_SHORT_US = 50;
   localparam int WD_LONG_CYCLES = WD_LONG_US * CLK_MHZ;
   localparam int WD_SHORT_CYCLES = WD_SHORT_US * CLK_MHZ;
   localparam int WD_COUNT_W = 26;
   localparam int RECOVER_HALF_NS = 5000;
   localparam int RECOVER_HALF_CYCLES = (RECOVER_HALF_NS * CLK_MHZ) / 1000;
   localparam int RECOVER_PULSES = 9;

   typedef enum logic [1:0] {
      SIL_WD_WATCH = 2'b00,
      SIL_WD_PULSE_LOW = 2'b01,
      SIL_WD_PULSE_HIGH = 2'b11,
      SIL_WD_FREE = 2'b10
   } sil_wd_state_e;
endpackage

// ---- rtl/sil_bus_watchdog.sv ----
module sil_bus_watchdog
   import sil_pkg::*;
#(
   parameter int LONG_CYCLES = WD_LONG_CYCLES
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic scl_i, // clock line level
   input wire logic sda_i, // data line level
   input wire logic speedup, // short timeout select
   input wire logic wd_disable, // suspend watchdog
   output logic scl_o, // clock line drive value
   output logic scl_oe, // clock line drive enable
   output logic bus_free // bus idle with data high
);
   logic scl_m, scl_s, scl_p;
   logic sda_m, sda_s, sda_p;
   logic [WD_COUNT_W-1:0] count;
   logic [WD_COUNT_W-1:0] limit;
   logic [8:0] half_count;
   logic [3:0] pulses;
   sil_wd_state_e state;
   logic activity;
   logic expired;
   logic half_done;

   always_ff @(posedge clk) begin
      if (rst) begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      end
   end

   assign activity = (scl_s != scl_p) || (sda_s != sda_p);
   assign limit = speedup ? WD_COUNT_W'(WD_SHORT_CYCLES - 1) : WD_COUNT_W'(LONG_CYCLES - 1);
   assign expired = (count >= limit);
   assign half_done = (half_count == 9'(RECOVER_HALF_CYCLES - 1));
   assign scl_o = 1'b0;
   assign scl_oe = (state == SIL_WD_PULSE_LOW);
   assign bus_free = (state == SIL_WD_FREE);

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= SIL_WD_WATCH;
         count <= '0;
         half_count <= '0;
         pulses <= '0;
      end else if (wd_disable) begin
         state <= SIL_WD_WATCH;
         count <= '0;
         half_count <= '0;
         pulses <= '0;
      end else begin
         unique case (state)
            SIL_WD_WATCH: begin
               if (activity) begin
                  count <= '0;
               end else if (expired) begin
                  count <= '0;
                  if (sda_s) begin
                     state <= SIL_WD_FREE;
                  end else begin
                     state <= SIL_WD_PULSE_LOW;
                     half_count <= '0;
                     pulses <= '0;
                  end
               end else begin
                  count <= count + 1'b1;
               end
            end
            SIL_WD_FREE: begin
               if (activity) begin
                  state <= SIL_WD_WATCH;
               end
            end
            SIL_WD_PULSE_LOW: begin
               half_count <= half_done ? 9'h000 : half_count + 1'b1;
               if (half_done) begin
                  state <= SIL_WD_PULSE_HIGH;
               end
            end
            SIL_WD_PULSE_HIGH: begin
               half_count <= half_done ? 9'h000 : half_count + 1'b1;
               if (half_done) begin
                  if (pulses == 4'(RECOVER_PULSES - 1)) begin
                     state <= SIL_WD_WATCH;
                     count <= '0;
                  end else begin
                     pulses <= pulses + 1'b1;
                     state <= SIL_WD_PULSE_LOW;
                  end
               end
            end
         endcase
      end
   end
endmodule

// ---- rtl/sil_link_status_regs.sv ----
// What this block does
// - watchdog about 1 s, or 50 us
// - disable bit suspends all watchdog action
// - data high and idle means free
// - data low and idle: nine clocks
// - remote id address; zero blocks access
// - auto-load id on lock unless held
// - hold bit keeps written id address
// - alias hits remap to slave0 target
// - zero alias or target blocks forwarding
// - 16-bit CRC count, two bytes, clearable
// - counters held cleared while clear set
// - self-test CRC flag with its clears
// - pixel clock detect held until invalid
// - normal CRC flag with its clears
// - link detect status bit
// - second port select redirects port fields
module sil_link_status_regs
   import sil_pkg::*;
#(
   parameter int LONG_CYCLES = WD_LONG_CYCLES
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [7:0] reg_addr, // register offset
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata, // read data, one cycle after address
   input wire logic second_port_select, // port 1 view of per-port fields
   input wire logic [1:0] link_detect, // cable link present per port
   input wire logic [1:0] rx_lock, // receiver lock per port
   input wire logic [1:0] id_load_valid, // id offered by control channel
   input wire logic [13:0] id_load_addr, // offered id, port 1 in upper 7 bits
   input wire logic [1:0] crc_error, // back-channel CRC error pulse
   input wire logic [1:0] selftest_active, // self-test running per port
   input wire logic [1:0] selftest_restart, // self-test restart pulse
   input wire logic pclk_valid, // valid pixel clock seen
   input wire logic pclk_out_of_range, // out-of-range pixel clock seen
   input wire logic scl_i, // clock line level
   input wire logic sda_i, // data line level
   output logic scl_o, // clock line drive value
   output logic scl_oe, // clock line drive enable
   output logic i2c_bus_free, // bus found free by watchdog
   input wire logic fwd_req, // local transaction address valid
   input wire logic fwd_port, // link port of the transaction
   input wire logic [6:0] fwd_addr_in, // local 7-bit address
   output logic fwd_hit, // transaction goes to remote slave 0
   output logic [6:0] fwd_addr, // remapped address
   output logic [1:0] deser_access_en, // remote deserializer reachable
   output logic [13:0] remote_deser_address // id per port, port 1 upper
);
   logic counter_clear;
   logic [7:0] i2c_control;
   logic pclk_detect;
   logic [6:0] deser_addr [2];
   logic hold_remote_id [2];
   logic [6:0] target [2];
   logic [6:0] alias_addr [2];
   logic [15:0] crc_count [2];
   logic selftest_crc_error_flag [2];
   logic deser_error_flag [2];
   logic [7:0] next_rdata;
   logic next_fwd_hit;
   logic [6:0] next_fwd_addr;
   logic cur;
   logic [7:0] status_byte;

   function automatic logic write_to(input logic [7:0] addr);
      return reg_wr && (reg_addr == addr);
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         counter_clear <= 1'b0;
         i2c_control <= RESET_BYTE;
         pclk_detect <= 1'b0;
      end else begin
         if (write_to(ADDR_MODE_SELECT)) begin
            counter_clear <= reg_wdata[MODE_COUNTER_CLEAR_BIT];
         end
         if (write_to(ADDR_I2C_CONTROL)) begin
            i2c_control <= reg_wdata & I2C_CONTROL_MASK;
         end
         // set wins, held until invalid clock
         if (pclk_valid) begin
            pclk_detect <= 1'b1;
         end else if (pclk_out_of_range) begin
            pclk_detect <= 1'b0;
         end
      end
   end

   sil_bus_watchdog #(
      .LONG_CYCLES(LONG_CYCLES)
   ) u_watchdog (
      .clk(clk),
      .rst(rst),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .speedup(i2c_control[I2C_WD_SPEEDUP_BIT]),
      .wd_disable(i2c_control[I2C_WD_DISABLE_BIT]),
      .scl_o(scl_o),
      .scl_oe(scl_oe),
      .bus_free(i2c_bus_free)
   );

   for (genvar p = 0; p < 2; p++) begin : g_port
      logic port_sel;
      logic normal_error;
      logic test_error;
      // writes land on the selected port
      assign port_sel = (second_port_select == 1'(p));
      assign normal_error = crc_error[p] && !selftest_active[p];
      assign test_error = crc_error[p] && selftest_active[p];

      always_ff @(posedge clk) begin
         if (rst) begin
            deser_addr[p] <= RESET_ADDR7;
            hold_remote_id[p] <= 1'b0;
            target[p] <= RESET_ADDR7;
            alias_addr[p] <= RESET_ADDR7;
         end else begin
            // written value kept with hold bit
            if (port_sel && write_to(ADDR_REMOTE_DESER_ID)) begin
               deser_addr[p] <= reg_wdata[7:1];
               hold_remote_id[p] <= reg_wdata[ID_HOLD_BIT];
            // auto-load on lock when not held
            end else if (id_load_valid[p] && rx_lock[p] && !hold_remote_id[p]) begin
               deser_addr[p] <= id_load_addr[p*7 +: 7];
            end
            if (port_sel && write_to(ADDR_REMOTE_SLAVE0_TARGET)) begin
               target[p] <= reg_wdata[7:1];
            end
            if (port_sel && write_to(ADDR_REMOTE_SLAVE0_ALIAS)) begin
               alias_addr[p] <= reg_wdata[7:1];
            end
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            crc_count[p] <= RESET_COUNT;
            selftest_crc_error_flag[p] <= 1'b0;
            deser_error_flag[p] <= 1'b0;
         end else begin
            // held cleared while clear bit set
            if (counter_clear) begin
               crc_count[p] <= RESET_COUNT;
            end else if (crc_error[p] && crc_count[p] != COUNT_MAX) begin
               crc_count[p] <= crc_count[p] + 16'h0001;
            end
            if (test_error) begin
               selftest_crc_error_flag[p] <= 1'b1;
            end else if (!link_detect[p] || selftest_restart[p] || counter_clear) begin
               selftest_crc_error_flag[p] <= 1'b0;
            end
            if (normal_error) begin
               deser_error_flag[p] <= 1'b1;
            end else if (!link_detect[p] || counter_clear) begin
               deser_error_flag[p] <= 1'b0;
            end
         end
      end

      assign deser_access_en[p] = (deser_addr[p] != RESET_ADDR7);
      assign remote_deser_address[p*7 +: 7] = deser_addr[p];
   end

   assign cur = second_port_select;

   always_comb begin
      status_byte = RESET_BYTE;
      status_byte[STATUS_SELFTEST_CRC_BIT] = selftest_crc_error_flag[cur];
      status_byte[STATUS_PCLK_DETECT_BIT] = pclk_detect;
      status_byte[STATUS_DESER_ERROR_BIT] = deser_error_flag[cur];
      status_byte[STATUS_LINK_DETECT_BIT] = link_detect[cur];
   end

   always_comb begin
      next_rdata = RESET_BYTE;
      unique case (reg_addr)
         ADDR_MODE_SELECT: next_rdata[MODE_COUNTER_CLEAR_BIT] = counter_clear;
         ADDR_I2C_CONTROL: next_rdata = i2c_control;
         ADDR_REMOTE_DESER_ID: next_rdata = {deser_addr[cur], hold_remote_id[cur]};
         ADDR_REMOTE_SLAVE0_TARGET: next_rdata = {target[cur], 1'b0};
         ADDR_REMOTE_SLAVE0_ALIAS: next_rdata = {alias_addr[cur], 1'b0};
         ADDR_CRC_ERROR_COUNT_LOW: next_rdata = crc_count[cur][7:0];
         ADDR_CRC_ERROR_COUNT_HIGH: next_rdata = crc_count[cur][15:8];
         ADDR_GENERAL_STATUS: next_rdata = status_byte;
         default: next_rdata = RESET_BYTE;
      endcase
   end

   // alias match remaps to target; zero fields block
   assign next_fwd_hit = fwd_req
                         && (alias_addr[fwd_port] != RESET_ADDR7)
                         && (target[fwd_port] != RESET_ADDR7)
                         && (fwd_addr_in == alias_addr[fwd_port]);
   assign next_fwd_addr = next_fwd_hit ? target[fwd_port] : fwd_addr_in;

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= RESET_BYTE;
         fwd_hit <= 1'b0;
         fwd_addr <= RESET_ADDR7;
      end else begin
         reg_rdata <= next_rdata;
         fwd_hit <= next_fwd_hit;
         fwd_addr <= next_fwd_addr;
      end
   end
endmodule

// ---- testbench/sil_link_status_regs_assertions.sv ----
module sil_link_status_regs_checker
   import sil_pkg::*;
#(
   parameter int LONG_CYCLES = WD_LONG_CYCLES
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [7:0] reg_addr, // register offset
   input wire logic reg_wr, // write strobe
   input wire logic [7:0] reg_rdata, // read data
   input wire logic second_port_select, // port 1 view
   input wire logic [1:0] link_detect, // link per port
   input wire logic [1:0] id_load_valid, // id offer per port
   input wire logic scl_o, // clock drive value
   input wire logic scl_oe, // clock drive enable
   input wire logic i2c_bus_free, // bus free flag
   input wire logic fwd_req, // remap request
   input wire logic [6:0] fwd_addr_in, // local address
   input wire logic fwd_hit, // remap hit
   input wire logic [6:0] fwd_addr, // remapped address
   input wire logic [1:0] deser_access_en, // deserializer reachable
   input wire logic [13:0] remote_deser_address // stored ids
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_miss;
      fwd_req ##1 !fwd_hit;
   endsequence
   // two synchroniser stages may sit before the link status bit
   sequence s_link_read;
      (reg_addr == ADDR_GENERAL_STATUS && !second_port_select && link_detect[0]) [*3];
   endsequence
   AST_ACCESS_EN: assert property (deser_access_en ==
      {|remote_deser_address[13:7], |remote_deser_address[6:0]}) else $error("access enable");
   AST_SCL_OPEN_DRAIN: assert property (scl_o == 1'b0) else $error("scl drives high");
   AST_FREE_QUIET: assert property (i2c_bus_free |-> !scl_oe) else $error("free yet driving");
   AST_ID_STABLE: assert property (!id_load_valid[0] && !reg_wr |=>
      $stable(remote_deser_address[6:0])) else $error("id changed unprompted");
   AST_ALIAS_ZERO: assert property (fwd_req && fwd_addr_in == 7'h00 |=> !fwd_hit)
      else $error("zero alias hit");
   AST_MISS_PASS: assert property (s_miss |-> fwd_addr == $past(fwd_addr_in))
      else $error("miss address altered");
   AST_NO_REQ: assert property (!fwd_req |=> !fwd_hit) else $error("hit without request");
   AST_PULSE_LEN: assert property ($rose(scl_oe) |-> ##249 scl_oe ##1 !scl_oe)
      else $error("recovery pulse length");
   AST_LINK_BIT: assert property (s_link_read |=> reg_rdata[0] && reg_rdata[7:4] == 4'h0)
      else $error("status read wrong");
   AST_UNMAPPED: assert property (reg_addr == 8'h09 |=> reg_rdata == 8'h00)
      else $error("unmapped read nonzero");
endmodule

bind sil_link_status_regs sil_link_status_regs_checker #(.LONG_CYCLES(LONG_CYCLES))
   sil_link_status_regs_checker_i (.clk, .rst, .reg_addr, .reg_wr, .reg_rdata,
   .second_port_select, .link_detect, .id_load_valid, .scl_o, .scl_oe, .i2c_bus_free,
   .fwd_req, .fwd_addr_in, .fwd_hit, .fwd_addr, .deser_access_en, .remote_deser_address);

// ---- testbench/sil_i2c_bus_model.sv ----
module sil_i2c_bus_model (
   input wire logic scl_o, // clock drive value
   input wire logic scl_oe, // clock drive enable
   input wire logic hold_sda_low, // stuck slave holds data low
   output logic scl, // resolved clock line
   output logic sda, // resolved data line
   output int falls // clock falls seen on the bus
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-ups win whenever nobody pulls a line low
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = hold_sda_low ? 1'b0 : 1'b1;
   initial falls = 0;
   always @(negedge scl) falls++;
endmodule

// ---- testbench/tb_sil_link_status_regs.sv ----
module tb_sil_link_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LONG = 3000;
   logic clk = 0, rst = 1, reg_wr = 0, second_port_select = 0, pclk_valid = 0;
   logic pclk_out_of_range = 0, fwd_req = 0, fwd_port = 0, hold_sda_low = 0;
   logic scl_i, sda_i, scl_o, scl_oe, i2c_bus_free, fwd_hit;
   logic [1:0] link_detect = '0, rx_lock = '0, id_load_valid = '0, crc_error = '0;
   logic [1:0] selftest_active = '0, selftest_restart = '0, deser_access_en;
   logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
   logic [13:0] id_load_addr = '0, remote_deser_address;
   logic [6:0] fwd_addr_in = '0, fwd_addr, a;
   logic [31:0] cnt = '0;
   logic [41:0] q[$], ent;
   int failures = 0, compares = 0, seed = 32'hF6A760E7, falls, n0;
   sil_link_status_regs #(.LONG_CYCLES(LONG)) sil_link_status_regs_i (.clk, .rst, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rdata, .second_port_select, .link_detect, .rx_lock,
      .id_load_valid, .id_load_addr, .crc_error, .selftest_active, .selftest_restart,
      .pclk_valid, .pclk_out_of_range, .scl_i, .sda_i, .scl_o, .scl_oe, .i2c_bus_free,
      .fwd_req, .fwd_port, .fwd_addr_in, .fwd_hit, .fwd_addr, .deser_access_en,
      .remote_deser_address);
   sil_i2c_bus_model sil_i2c_bus_model_i (.scl_o, .scl_oe, .hold_sda_low, .scl(scl_i),
      .sda(sda_i), .falls);
   initial forever #10 clk = ~clk;
   task automatic check(string n, logic [7:0] s, logic [7:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      // a note that was never compared counts against the run
      if (q.size() != 0) failures++;
      if (failures == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // each task sets every strobe once, so back-to-back calls never glitch them
   task automatic cyc(int n);
      reg_wr = 0;
      fwd_req = 0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [7:0] ad, logic [7:0] d);
      reg_addr = ad;
      reg_wdata = d;
      reg_wr = 1;
      fwd_req = 0;
      @(posedge clk);
      #1;
   endtask
   // kind 0 rdata, 1 remap, 2 level outputs, 3 clock falls; lag 0 compares at the next edge
   task automatic note(logic [1:0] k, logic [31:0] lag, logic [7:0] e);
      q.push_back({k, cnt + lag, e});
   endtask
   // registered answer is due one edge after the design samples the request
   task automatic rd(logic [7:0] ad, logic [7:0] e);
      note(2'h0, 32'h1, e);
      reg_addr = ad;
      cyc(1);
   endtask
   task automatic fw(logic p, logic [6:0] ad, logic [7:0] e);
      note(2'h1, 32'h1, e);
      fwd_port = p;
      fwd_addr_in = ad;
      reg_wr = 0;
      fwd_req = 1;
      @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      cnt <= cnt + 32'h1;
      // several notes may fall due on one edge
      while (q.size() != 0 && q[0][39:8] == cnt) begin
         ent = q.pop_front();
         case (ent[41:40])
            2'h0: check("rdata", reg_rdata, ent[7:0]);
            2'h1: check("fwd", {fwd_hit, fwd_addr}, ent[7:0]);
            2'h2: check("outs", {5'h00, deser_access_en, i2c_bus_free}, ent[7:0]);
            default: check("falls", 8'(falls - n0), ent[7:0]);
         endcase
      end
   end
   initial begin
      cyc(2);
      rst = 0;
      note(2'h2, 32'h0, 8'h00);
      rd(8'h06, 8'h00);
      rd(8'h07, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h00);
      rd(8'h0B, 8'h00);
      rx_lock = 2'b11;
      link_detect = 2'b11;
      id_load_addr = {7'h33, 7'h12};
      id_load_valid = 2'b11;
      cyc(1);
      id_load_valid = '0;
      rd(8'h06, 8'h24);
      second_port_select = 1;
      rd(8'h06, 8'h66);
      second_port_select = 0;
      // software freezes the address it writes
      wr(8'h06, 8'h35);
      id_load_valid = 2'b01;
      cyc(1);
      id_load_valid = '0;
      rd(8'h06, 8'h35);
      wr(8'h07, 8'h42);
      wr(8'h08, 8'h5A);
      fw(0, 7'h2D, 8'hA1);
      repeat (20) begin
         a = 7'($random(seed));
         if (a == 7'h2D) a = 7'h2C;
         fw(0, a, {1'b0, a});
      end
      fw(0, 7'h00, 8'h00);
      fw(1, 7'h2D, 8'h2D);
      wr(8'h07, 8'h00);
      fw(0, 7'h2D, 8'h2D);
      crc_error = 2'b01;
      cyc(3);
      crc_error = '0;
      rd(8'h0A, 8'h03);
      rd(8'h0C, 8'h03);
      selftest_active = 2'b01;
      crc_error = 2'b01;
      cyc(1);
      crc_error = '0;
      selftest_active = '0;
      rd(8'h0A, 8'h04);
      rd(8'h0C, 8'h0B);
      selftest_restart = 2'b01;
      cyc(1);
      selftest_restart = '0;
      rd(8'h0C, 8'h03);
      second_port_select = 1;
      rd(8'h0A, 8'h00);
      second_port_select = 0;
      wr(8'h04, 8'h20);
      crc_error = 2'b01;
      cyc(2);
      crc_error = '0;
      cyc(1);
      rd(8'h0A, 8'h00);
      rd(8'h0C, 8'h01);
      rd(8'h04, 8'h20);
      wr(8'h04, 8'h00);
      crc_error = 2'b01;
      cyc(1);
      crc_error = '0;
      link_detect = 2'b10;
      cyc(1);
      rd(8'h0C, 8'h00);
      link_detect = 2'b11;
      pclk_valid = 1;
      cyc(1);
      pclk_valid = 0;
      cyc(5);
      rd(8'h0C, 8'h05);
      pclk_out_of_range = 1;
      cyc(1);
      pclk_out_of_range = 0;
      cyc(1);
      rd(8'h0C, 8'h01);
      crc_error = 2'b10;
      cyc(65540);
      crc_error = '0;
      second_port_select = 1;
      rd(8'h0A, 8'hFF);
      rd(8'h0B, 8'hFF);
      second_port_select = 0;
      rd(8'h0A, 8'h01);
      note(2'h2, 32'h0, 8'h07);
      wr(8'h05, 8'h02);
      hold_sda_low = 1;
      n0 = falls;
      cyc(2600);
      note(2'h3, 32'h0, 8'h01);
      cyc(4600);
      note(2'h3, 32'h0, 8'h09);
      wr(8'h05, 8'h03);
      n0 = falls;
      cyc(3200);
      note(2'h3, 32'h0, 8'h00);
      hold_sda_low = 0;
      cyc(3);
      complete_run();
   end
   initial begin
      #1700000;
      failures++;
      complete_run();
   end
endmodule
